/* File: verification/esd_field_model.sv */
module esd_field_model
(
   // Clock
   input  wire logic        clk,
   // Line levels and aux clock request from the bench
   input  wire logic [46:0] lines,
   input  wire logic        aux_run,
   // Field side
   output logic      [47:0] io_in
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [1:0] div_r = 2'h0;
   logic       aux_r = 1'b0;

   // Aux clock stands still unless a test asks for it, period 8 cycles
   always_ff @(posedge clk)
   begin
      if (aux_run)
      begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3)
            aux_r <= ~aux_r;
      end
   end

   // Top line only ever carries the aux clock, never port output data
   assign io_in = {aux_r, lines};
endmodule

/* File: verification/esd_unit_test.sv */
module esd_unit_test
   import esd_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int LIM2 = 20;
   localparam int LIM3 = 40;

   logic        clk;
   logic        rstn;
   logic        reg_wr;
   logic        reg_rd;
   logic [2:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic [7:0]  reg_rdata;
   logic        enhanced_mode;
   logic        int_enable;
   logic [46:0] lines;
   logic        aux_run;
   logic [47:0] io_in;
   logic [47:0] line_level;
   logic        irq;
   int          errors;
   int          checks_done;
   int          cycles;
   int          lim [4];
   logic        lv;

   esd_field_model u_field
   (
      .clk     (clk),
      .lines   (lines),
      .aux_run (aux_run),
      .io_in   (io_in)
   );

   esd_unit #(
      .BUS_LIM2 (LIM2),
      .BUS_LIM3 (LIM3),
      .EXT_LIM2 (8),
      .EXT_LIM3 (16)
   ) DUT
   (
      .clk                         (clk),
      .rstn                        (rstn),
      .reg_wr                      (reg_wr),
      .reg_rd                      (reg_rd),
      .reg_addr                    (reg_addr),
      .reg_wdata                   (reg_wdata),
      .reg_rdata                   (reg_rdata),
      .enhanced_mode               (enhanced_mode),
      .int_enable                  (int_enable),
      .io_in                       (io_in),
      .line_level                  (line_level),
      .interrupt_request_line_zero (irq)
   );

   always #25 clk = ~clk;

   task test_done();
      if (errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 10000)
      begin
         errors++;
         test_done();
      end
   end

   task chk_byte(input string nm, input logic [7:0] exp,
                 input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task chk_bit(input string nm, input logic exp, input logic got);
      checks_done++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %s expected %b seen %b", nm, exp, got);
      end
   endtask

   task wait_n(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd   <= 1'b0;
      wait_n(1);
      chk_byte("reg_rdata", exp, reg_rdata);
   endtask

   initial
   begin
      clk = 1'b0;
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 3'h0;
      reg_wdata = 8'h00;
      enhanced_mode = 1'b0;
      int_enable = 1'b0;
      lines = 47'h20;
      aux_run = 1'b0;
      errors = 0;
      checks_done = 0;
      cycles = 0;
      lim = '{BUS_CNT0, BUS_CNT1, LIM2, LIM3};
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      enhanced_mode <= 1'b1;
      wait_n(1);
      chk_byte("reg_rdata", 8'h00, reg_rdata);
      chk_bit("irq", 1'b0, irq);
      rd(PORT_BANK, 8'h00);
      // Debounce bank registers, every duration code written
      wr(PORT_BANK, 8'h80);
      rd(PORT_BANK, 8'h80);
      for (int p = 0; p < 4; p++) rd(3'(p), 8'h00);
      wr(PORT_DEB_EN, 8'h3f);
      rd(PORT_DEB_EN, 8'h3f);
      wr(PORT_DUR_LO, 8'he4);
      rd(PORT_DUR_LO, 8'he4);
      wr(PORT_DUR_HI, 8'h0e);
      rd(PORT_DUR_HI, 8'h0e);
      wr(PORT_CLK_SEL, 8'hff);
      rd(PORT_CLK_SEL, 8'h01);
      wr(PORT_DEB_EN, 8'h00);
      rd(PORT_DEB_EN, 8'h00);
      // Event bank: polarity first, then enable
      wr(PORT_BANK, 8'h40);
      rd(PORT_BANK, 8'h40);
      wr(PORT_SUMMARY, 8'h01);
      wr(PORT_BANK, 8'h48);
      lines[2] <= 1'b1;
      wait_n(6);
      rd(3'h0, 8'h00);
      wr(3'h0, 8'hff);
      wr(3'h5, 8'hff);
      lines[1] <= 1'b1;
      lines[5] <= 1'b0;
      lines[6] <= 1'b1;
      lines[44] <= 1'b1;
      wait_n(6);
      rd(3'h0, 8'h22);
      rd(3'h5, 8'h10);
      rd(PORT_SUMMARY, 8'ha1);
      chk_bit("irq", 1'b0, irq);
      @(posedge clk);
      int_enable <= 1'b1;
      wait_n(3);
      chk_bit("irq", 1'b1, irq);
      wr(3'h0, 8'hdd);
      wr(3'h0, 8'hff);
      lines[1] <= 1'b0;
      wait_n(6);
      rd(3'h0, 8'h00);
      wr(3'h5, 8'h00);
      rd(PORT_SUMMARY, 8'h00);
      chk_bit("irq", 1'b0, irq);
      // Debounce on bus clock, every duration code
      wr(PORT_BANK, 8'h80);
      wr(PORT_CLK_SEL, 8'h01);
      wr(PORT_DEB_EN, 8'h01);
      lv = 1'b0;
      for (int c = 0; c < 4; c++)
      begin
         wr(PORT_DUR_LO, 8'(c));
         lv = ~lv;
         lines[0] <= lv;
         wait_n(lim[c] - 5);
         chk_bit("line_level", ~lv, line_level[0]);
         wait_n(13);
         chk_bit("line_level", lv, line_level[0]);
      end
      // Debounce on aux clock: frozen while it stands still
      wr(PORT_CLK_SEL, 8'h00);
      wr(PORT_DUR_LO, 8'h02);
      lv = ~lv;
      lines[0] <= lv;
      wait_n(100);
      chk_bit("line_level", ~lv, line_level[0]);
      @(posedge clk);
      aux_run <= 1'b1;
      wait_n(40);
      chk_bit("line_level", ~lv, line_level[0]);
      wait_n(60);
      chk_bit("line_level", lv, line_level[0]);
      // Outside enhanced mode the filter is bypassed
      @(posedge clk);
      aux_run <= 1'b0;
      enhanced_mode <= 1'b0;
      lv = ~lv;
      lines[0] <= lv;
      wait_n(4);
      chk_bit("line_level", lv, line_level[0]);
      // Back to the I/O bank
      wr(PORT_BANK, 8'h00);
      rd(PORT_BANK, 8'h00);
      test_done();
   end
endmodule

/* File: verilog/esd_debounce.sv */
module esd_debounce
   import esd_pkg::*;
#(
   parameter int LINES    = LINES_PER_PORT,
   parameter int CNT_W    = DB_CNT_W,
   parameter int BUS_LIM2 = BUS_CNT2,
   parameter int BUS_LIM3 = BUS_CNT3,
   parameter int EXT_LIM2 = EXT_CNT2,
   parameter int EXT_LIM3 = EXT_CNT3
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rstn,
   // Control
   input  wire logic             filter_on,
   input  wire logic [1:0]       code,
   input  wire logic             ext_sel,
   input  wire logic             ext_tick,
   // Lines
   input  wire logic [LINES-1:0] raw,
   output logic      [LINES-1:0] level
);

   logic [CNT_W-1:0] limit;
   logic             step;

   always_comb
   begin
      case ({ext_sel, code})
         3'h0:    limit = CNT_W'(BUS_CNT0);
         3'h1:    limit = CNT_W'(BUS_CNT1);
         3'h2:    limit = CNT_W'(BUS_LIM2);
         3'h3:    limit = CNT_W'(BUS_LIM3);
         3'h4:    limit = CNT_W'(EXT_CNT0);
         3'h5:    limit = CNT_W'(EXT_CNT1);
         3'h6:    limit = CNT_W'(EXT_LIM2);
         default: limit = CNT_W'(EXT_LIM3);
      endcase
   end

   assign step = ext_sel ? ext_tick : 1'b1;

   genvar i;
   generate
      for (i = 0; i < LINES; i++)
      begin : g_line
         logic [CNT_W-1:0] cnt_r;
         logic             stable_r;

         // With the filter on, a change is accepted only after it held for limit steps
         always_ff @(posedge clk)
         begin
            if (!rstn)
            begin
               cnt_r    <= '0;
               stable_r <= 1'b0;
            end
            else if (!filter_on || raw[i] == stable_r)
            begin
               cnt_r    <= '0;
               stable_r <= raw[i];
            end
            else if (step)
            begin
               if (cnt_r >= limit - CNT_W'(1))
               begin
                  cnt_r    <= '0;
                  stable_r <= raw[i];
               end
               else
                  cnt_r <= cnt_r + CNT_W'(1);
            end
         end

         assign level[i] = filter_on ? stable_r : raw[i];
      end
   endgenerate

endmodule

/* File: verilog/esd_pkg.sv */
package esd_pkg;

   // Geometry
   localparam int NUM_PORTS      = 6;
   localparam int LINES_PER_PORT = 8;
   localparam int NUM_LINES      = 48;
   localparam int LINES_PER_GRP  = 4;
   localparam int NUM_GROUPS     = 12;
   localparam int POL_LO_GROUPS  = 8;
   localparam int AUX_CLK_LINE   = 47;

   // Register bank codes, in select-field order
   typedef enum logic [1:0]
   {
      BANK_IO,
      BANK_EVENT,
      BANK_DEBOUNCE,
      BANK_INVALID
   } esd_bank_t;

   // Port offsets inside a bank
   localparam logic [2:0] PORT_DEB_EN  = 3'h0;
   localparam logic [2:0] PORT_DUR_LO  = 3'h1;
   localparam logic [2:0] PORT_DUR_HI  = 3'h2;
   localparam logic [2:0] PORT_CLK_SEL = 3'h3;
   localparam logic [2:0] PORT_SUMMARY = 3'h6;
   localparam logic [2:0] PORT_BANK    = 3'h7;

   // Field positions
   localparam int SUMMARY_BIT = 7;
   localparam int BANK_LSB    = 6;
   localparam int POL_HI_W    = 4;
   localparam int DUR_HI_W    = 4;

   // Debounce timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int DB_T0_NS      = 4000;
   localparam int DB_T1_NS      = 64000;
   localparam int DB_T2_NS      = 1000000;
   localparam int DB_T3_NS      = 8000000;
   localparam int BUS_CNT0      = DB_T0_NS / CLK_PERIOD_NS;
   localparam int BUS_CNT1      = DB_T1_NS / CLK_PERIOD_NS;
   localparam int BUS_CNT2      = DB_T2_NS / CLK_PERIOD_NS;
   localparam int BUS_CNT3      = DB_T3_NS / CLK_PERIOD_NS;
   localparam int EXT_CNT0      = 32;
   localparam int EXT_CNT1      = 512;
   localparam int EXT_CNT2      = 8000;
   localparam int EXT_CNT3      = 64000;
   localparam int DB_CNT_W      = 18;

endpackage

/* File: verilog/esd_unit.sv */
module esd_unit
   import esd_pkg::*;
#(
   parameter int BUS_LIM2 = BUS_CNT2,
   parameter int BUS_LIM3 = BUS_CNT3,
   parameter int EXT_LIM2 = EXT_CNT2,
   parameter int EXT_LIM3 = EXT_CNT3
)
(
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rstn,
   // Register port
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [2:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output logic      [7:0]           reg_rdata,
   // Mode and interrupt control
   input  wire logic                 enhanced_mode,
   input  wire logic                 int_enable,
   // Field lines
   input  wire logic [NUM_LINES-1:0] io_in,
   output logic      [NUM_LINES-1:0] line_level,
   // Interrupt request
   output logic                      interrupt_request_line_zero
);

   logic [NUM_LINES-1:0]  sync1_r;
   logic [NUM_LINES-1:0]  sync2_r;
   logic                  aux_prev_r;
   logic                  ext_tick;
   esd_bank_t             bank_r;
   logic [NUM_GROUPS-1:0] pol_r;
   logic [NUM_LINES-1:0]  en_r;
   logic [NUM_LINES-1:0]  ev_r;
   logic [NUM_PORTS-1:0]  deb_en_r;
   logic [2*NUM_PORTS-1:0] dur_r;
   logic                  clk_sel_r;
   logic [NUM_LINES-1:0]  filt;
   logic [NUM_LINES-1:0]  prev_r;
   logic [NUM_LINES-1:0]  edge_det;
   logic [NUM_LINES-1:0]  wr_hit;
   logic [NUM_LINES-1:0]  wdata_all;
   logic [NUM_PORTS-1:0]  port_or;
   logic [7:0]            ev_byte [NUM_PORTS];
   logic                  summary;
   logic                  wr_event;
   logic                  wr_deb;
   logic [7:0]            rdata_r;
   logic                  irq_r;

   // Pin synchronisers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= io_in;
         sync2_r <= sync1_r;
      end
   end

   // External debounce clock edge from the aux line
   always_ff @(posedge clk)
   begin
      if (!rstn)
         aux_prev_r <= 1'b0;
      else
         aux_prev_r <= sync2_r[AUX_CLK_LINE];
   end

   assign ext_tick = sync2_r[AUX_CLK_LINE] & ~aux_prev_r;

   assign wr_event = reg_wr && bank_r == BANK_EVENT;
   assign wr_deb   = reg_wr && bank_r == BANK_DEBOUNCE;

   // Bank select, any bank's port 7
   always_ff @(posedge clk)
   begin
      if (!rstn)
         bank_r <= BANK_IO;
      else if (reg_wr && reg_addr == PORT_BANK &&
               reg_wdata[7:BANK_LSB] != BANK_INVALID)
         bank_r <= esd_bank_t'(reg_wdata[7:BANK_LSB]);
   end

   // Edge polarity per group of four lines
   always_ff @(posedge clk)
   begin
      if (!rstn)
         pol_r <= '0;
      else if (wr_event && reg_addr == PORT_SUMMARY)
         pol_r[POL_LO_GROUPS-1:0] <= reg_wdata;
      else if (wr_event && reg_addr == PORT_BANK)
         pol_r[NUM_GROUPS-1:POL_LO_GROUPS] <=
            reg_wdata[POL_HI_W-1:0];
   end

   // Debounce configuration
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         deb_en_r  <= '0;
         dur_r     <= '0;
         clk_sel_r <= 1'b0;
      end
      else if (wr_deb)
      begin
         case (reg_addr)
            PORT_DEB_EN:  deb_en_r <= reg_wdata[NUM_PORTS-1:0];
            PORT_DUR_LO:  dur_r[7:0] <= reg_wdata;
            PORT_DUR_HI:  dur_r[2*NUM_PORTS-1:8] <=
                             reg_wdata[DUR_HI_W-1:0];
            PORT_CLK_SEL: clk_sel_r <= reg_wdata[0];
            default:      deb_en_r <= deb_en_r;
         endcase
      end
   end

   // Debounce per port
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++)
      begin : g_port
         esd_debounce #(
            .LINES    (LINES_PER_PORT),
            .CNT_W    (DB_CNT_W),
            .BUS_LIM2 (BUS_LIM2),
            .BUS_LIM3 (BUS_LIM3),
            .EXT_LIM2 (EXT_LIM2),
            .EXT_LIM3 (EXT_LIM3)
         ) u_deb (
            .clk       (clk),
            .rstn      (rstn),
            .filter_on (deb_en_r[p] & enhanced_mode),
            .code      (dur_r[2*p +: 2]),
            .ext_sel   (~clk_sel_r),
            .ext_tick  (ext_tick),
            .raw       (sync2_r[p*LINES_PER_PORT +: LINES_PER_PORT]),
            .level     (filt[p*LINES_PER_PORT +: LINES_PER_PORT])
         );
         assign ev_byte[p] = ev_r[p*LINES_PER_PORT +: LINES_PER_PORT];
         assign port_or[p] = |ev_byte[p];
         assign wr_hit[p*LINES_PER_PORT +: LINES_PER_PORT] =
            {LINES_PER_PORT{wr_event && reg_addr == 3'(p)}};
         assign wdata_all[p*LINES_PER_PORT +: LINES_PER_PORT] = reg_wdata;
      end
   endgenerate

   // Edge detection on the filtered lines
   genvar i;
   generate
      for (i = 0; i < NUM_LINES; i++)
      begin : g_edge
         assign edge_det[i] = enhanced_mode && en_r[i] &&
            (pol_r[i/LINES_PER_GRP] ? (filt[i] & ~prev_r[i])
                                    : (~filt[i] & prev_r[i]));
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         prev_r     <= '0;
         line_level <= '0;
      end
      else
      begin
         prev_r     <= filt;
         line_level <= filt;
      end
   end

   // Event latches and sense enables; a new edge wins over a clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         en_r <= '0;
         ev_r <= '0;
      end
      else
      begin
         en_r <= (en_r & ~wr_hit) | (wr_hit & wdata_all);
         ev_r <= (ev_r & ~(wr_hit & ~wdata_all)) | edge_det;
      end
   end

   assign summary = |ev_r;

   // Read data
   always_ff @(posedge clk)
   begin
      if (!rstn)
         rdata_r <= '0;
      else if (reg_rd)
      begin
         rdata_r <= '0;
         if (reg_addr == PORT_BANK)
            rdata_r <= {bank_r, 6'h00};
         else if (bank_r == BANK_EVENT)
         begin
            if (reg_addr == PORT_SUMMARY)
               rdata_r <= {summary, 1'b0, port_or};
            else
               rdata_r <= ev_byte[reg_addr];
         end
         else if (bank_r == BANK_DEBOUNCE)
         begin
            case (reg_addr)
               PORT_DEB_EN:  rdata_r <= {2'h0, deb_en_r};
               PORT_DUR_LO:  rdata_r <= dur_r[7:0];
               PORT_DUR_HI:  rdata_r <= {4'h0, dur_r[2*NUM_PORTS-1:8]};
               PORT_CLK_SEL: rdata_r <= {7'h00, clk_sel_r};
               default:      rdata_r <= '0;
            endcase
         end
      end
   end

   // Interrupt request
   always_ff @(posedge clk)
   begin
      if (!rstn)
         irq_r <= 1'b0;
      else
         irq_r <= summary && int_enable && enhanced_mode;
   end

   assign reg_rdata                   = rdata_r;
   assign interrupt_request_line_zero = irq_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_irq_needs_en: assert property (
      !$past(int_enable) |-> !interrupt_request_line_zero)
      else $error("Request raised while interrupts disabled");

   a_irq_follows: assert property (
      (summary && int_enable && enhanced_mode) ##1
      (int_enable && enhanced_mode) |-> interrupt_request_line_zero)
      else $error("Request missing with pending event");

   a_summary_read: assert property (
      (reg_rd && bank_r == BANK_EVENT && reg_addr == PORT_SUMMARY)
      |=> reg_rdata[6] == 1'b0 &&
          reg_rdata[5:0] == $past(port_or))
      else $error("Port status read wrong");

   a_summary_flag: assert property (
      (reg_rd && bank_r == BANK_EVENT && reg_addr == PORT_SUMMARY)
      |=> reg_rdata[SUMMARY_BIT] == ($past(ev_r) != '0))
      else $error("Summary flag wrong");

   a_pol_low: assert property (
      (reg_wr && bank_r == BANK_EVENT && reg_addr == PORT_SUMMARY)
      |=> pol_r[7:0] == $past(reg_wdata))
      else $error("Low polarity not written");

   a_pol_high: assert property (
      (reg_wr && bank_r == BANK_EVENT && reg_addr == PORT_BANK)
      |=> pol_r[NUM_GROUPS-1:POL_LO_GROUPS] == $past(reg_wdata[3:0]))
      else $error("High polarity not written");

   a_no_evt_off: assert property (
      (ev_r & ~$past(ev_r) & ~$past(en_r)) == '0)
      else $error("Event latched on disabled line");

   a_evt_cause: assert property (
      (ev_r & ~$past(ev_r) & ~$past(edge_det)) == '0)
      else $error("Event latched without an edge");

   a_bank_sel: assert property (
      (reg_wr && reg_addr == PORT_BANK &&
       reg_wdata[7:BANK_LSB] != BANK_INVALID)
      |=> bank_r == $past(reg_wdata[7:BANK_LSB]))
      else $error("Bank select wrong");

   a_bank_keep: assert property (
      (reg_wr && reg_addr == PORT_BANK &&
       reg_wdata[7:BANK_LSB] == BANK_INVALID)
      |=> bank_r == $past(bank_r))
      else $error("Invalid bank code changed the bank");

   a_bank_read: assert property (
      (reg_rd && reg_addr == PORT_BANK)
      |=> reg_rdata == {$past(bank_r), 6'h00})
      else $error("Bank status read wrong");

   a_clksel_zero: assert property (
      (reg_rd && bank_r == BANK_DEBOUNCE && reg_addr == PORT_CLK_SEL)
      |=> reg_rdata[7:1] == 7'h00)
      else $error("Clock select upper bits not zero");

   a_reset_vals: assert property (
      $past(!rstn) |-> ev_r == '0 && en_r == '0 && pol_r == '0 &&
                       deb_en_r == '0 && !clk_sel_r &&
                       dur_r == '0 && bank_r == BANK_IO)
      else $error("Reset state wrong");

   a_latch_read: assert property (
      (reg_rd && bank_r == BANK_EVENT && reg_addr < PORT_SUMMARY)
      |=> reg_rdata == $past(ev_byte[reg_addr]))
      else $error("Event latch read wrong");

   a_edge_sets: assert property (
      (edge_det != '0)
      |=> (ev_r & $past(edge_det)) == $past(edge_det))
      else $error("Sensed edge did not set its latch");

   a_deb_write: assert property (
      (wr_deb && reg_addr == PORT_DEB_EN)
      |=> deb_en_r == $past(reg_wdata[NUM_PORTS-1:0]))
      else $error("Debounce enables not written");

   c_event_set:  cover property ($rose(summary));
   c_irq:        cover property ($rose(interrupt_request_line_zero));
   c_bank_deb:   cover property (bank_r == BANK_DEBOUNCE);
   c_ext_filter: cover property (!clk_sel_r && deb_en_r != '0 && summary);
   c_clear:      cover property ($fell(summary));

endmodule
